// ===== rtl/clse_console.sv
// console load, step and execute path with its register port
// assumes an Avalon-MM master on the register bus and one clock
`timescale 1ns/100ps
module clse_console import clse_pkg::*; #(
    parameter int MEM_WORDS = 65536
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [BUS_AW-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [BUS_DW-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [BUS_DW-1:0] readdata,
    output logic waitrequest,
    output logic [15:0] lamps
);
    generate
        if (MEM_WORDS < 2 || MEM_WORDS > 65536) begin : g_chk
            $error("clse_console: MEM_WORDS out of range");
        end
    endgenerate

    function automatic logic hit(input logic [BUS_AW-1:0] a,
                                 input logic [BUS_AW-1:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8],
                   be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // state
    clse_state_t state;
    clse_state_t next_state;
    clse_ctrl_t ctrl;
    logic [15:0] entry;
    logic [15:0] pc;
    logic [15:0] ir;
    logic [15:0] ptr;
    logic [15:0] opAddr;
    logic [15:0] gpr [GPR_N];
    logic waitFlag;
    logic rdAck;

    // bus decode
    wire logic wrCtrl;
    wire logic wrEntry;
    wire logic wrCmd;
    wire logic busEnter;
    wire logic busStep;
    wire logic busy;
    wire logic enterNow;
    wire logic stepNow;

    assign wrCtrl = write & hit(address, REG_CTRL) & byteenable[0];
    assign wrEntry = write & hit(address, REG_ENTRY);
    assign wrCmd = write & hit(address, REG_CMD) & byteenable[0];
    assign busEnter = wrCmd & writedata[CMD_ENTER];
    // enter wins when both bits come in one write
    assign busStep = wrCmd & writedata[CMD_STEP] & ~writedata[CMD_ENTER];
    assign busy = (state != ST_IDLE);
    // presses during a step are dropped, never queued
    assign enterNow = busEnter & ~busy;
    assign stepNow = busStep & ~busy;

    // reads take one wait cycle so read data come from flip-flops
    assign waitrequest = read & ~rdAck;

    // instruction decode
    wire logic isStore;
    wire logic isLoad;
    wire logic isInd;
    wire logic isHalt;

    assign isStore = (ir == OP_STORE_ACC);
    assign isLoad = (ir == OP_LOAD_ACC);
    assign isInd = ((ir & OP_IND_MASK) == OP_IND_LOAD);
    assign isHalt = (ir == HALT_WORD);

    // address arithmetic, all 16 bits and wrapping
    wire logic [15:0] pcInc;
    wire logic [15:0] ptrAddr;
    wire logic [15:0] indAddr;

    assign pcInc = pc + WORD_ONE;
    assign ptrAddr = gpr[GPR_BASE] + {DISP_PAD, ir[7:0]};
    assign indAddr = ptr + gpr[GPR_INDEX];

    // memory port
    clse_mem_req_t memReq;
    wire logic [15:0] memRdata;
    wire logic inFetch;
    wire logic inExec;
    wire logic inIndir;

    assign inFetch = (state == ST_FETCH);
    assign inExec = (state == ST_EXEC);
    assign inIndir = (state == ST_INDIR);

    // fetch at pc, pointer at base+disp, operand at pointer+index,
    // direct store and load at the incremented pc
    assign memReq.addr = inFetch ? pc :
                         inIndir ? indAddr :
                         (inExec & isInd) ? ptrAddr :
                         pcInc;
    assign memReq.we = inExec & isStore;
    assign memReq.data = gpr[GPR_ACC];

    clse_core_mem #(
        .WORDS(MEM_WORDS)
    ) u_mem (
        .clk(clk),
        .req(memReq),
        .rdata(memRdata)
    );

    // register loads
    wire logic enterPc;
    wire logic enterIr;
    wire logic enterGpr;
    wire logic accLoad;
    wire logic gprWe;
    wire logic [2:0] gprIdx;
    wire logic [15:0] gprData;

    assign enterPc = enterNow & ctrl.pcSel;
    assign enterIr = enterNow & ~ctrl.pcSel & ctrl.irSel;
    assign enterGpr = enterNow & ~ctrl.pcSel & ~ctrl.irSel;
    assign accLoad = (inExec & isLoad) | inIndir;
    assign gprWe = enterGpr | accLoad;
    assign gprIdx = accLoad ? GPR_ACC : ctrl.gprCode;
    assign gprData = accLoad ? memRdata : entry;

    // next values
    wire logic [15:0] next_pc;
    wire logic [15:0] next_ir;
    wire logic [15:0] next_lamps;
    wire logic [15:0] next_opAddr;

    assign next_pc = enterPc ? entry :
                     inExec ? pcInc :
                     pc;
    assign next_ir = enterIr ? entry :
                     inFetch ? memRdata :
                     ir;
    assign next_lamps = accLoad ? memRdata :
                        enterNow ? entry :
                        lamps;
    assign next_opAddr = inIndir ? indAddr :
                         (inExec & (isStore | isLoad)) ? pcInc :
                         opAddr;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (stepNow) begin
                    next_state = ctrl.keep ? ST_EXEC : ST_FETCH;
                end
            end
            ST_FETCH: begin
                next_state = ST_EXEC;
            end
            ST_EXEC: begin
                next_state = isInd ? ST_INDIR : ST_IDLE;
            end
            ST_INDIR: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pc <= WORD_ZERO;
            ir <= WORD_ZERO;
            lamps <= WORD_ZERO;
            opAddr <= WORD_ZERO;
        end else begin
            pc <= next_pc;
            ir <= next_ir;
            lamps <= next_lamps;
            opAddr <= next_opAddr;
        end
    end

    // pointer word from base plus displacement, held for the next state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ptr <= WORD_ZERO;
        end else if (inExec & isInd) begin
            ptr <= memRdata;
        end
    end

    // halt-and-wait marker; a new step clears it, a halt in the same
    // cycle cannot happen because a step only starts from idle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            waitFlag <= 1'b0;
        end else if (inExec & isHalt) begin
            waitFlag <= 1'b1;
        end else if (stepNow) begin
            waitFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < GPR_N; i++) begin
                gpr[i] <= WORD_ZERO;
            end
        end else if (gprWe) begin
            gpr[gprIdx] <= gprData;
        end
    end

    // operator switches held as registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl <= CTRL_RST;
        end else if (wrCtrl) begin
            ctrl <= clse_ctrl_t'(writedata[5:0]);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            entry <= WORD_ZERO;
        end else if (wrEntry) begin
            entry <= merge16(entry, writedata, byteenable);
        end
    end

    // read path
    wire logic isGprAddr;
    wire logic [2:0] gprRdIdx;
    wire logic [15:0] status;
    logic [15:0] rdMux;

    assign isGprAddr = ((address & REG_GPR_MASK) == REG_GPR0);
    assign gprRdIdx = address[4:2];
    assign status = {14'h0000, waitFlag, busy};

    always_comb begin
        rdMux = WORD_ZERO;
        if (isGprAddr) begin
            rdMux = gpr[gprRdIdx];
        end else begin
            unique case (address)
                REG_CTRL: rdMux = {10'h000, ctrl};
                REG_ENTRY: rdMux = entry;
                REG_STATUS: rdMux = status;
                REG_PC: rdMux = pc;
                REG_IR: rdMux = ir;
                REG_LAMPS: rdMux = lamps;
                REG_OPADDR: rdMux = opAddr;
                default: rdMux = WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdAck <= 1'b0;
            readdata <= '0;
        end else begin
            rdAck <= read & ~rdAck;
            if (read & ~rdAck) begin
                readdata <= {16'h0000, rdMux};
            end
        end
    end
endmodule

// ===== rtl/clse_pkg.sv
// constants, field layouts and carrier types of the console step block
// assumes a single 10 MHz clock and word-wide core memory
package clse_pkg;
    localparam int WORD_W = 16;
    localparam int GPR_N = 8;
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;
    localparam real CLK_PERIOD_NS = 100.0;

    // instruction words decoded on a step, then word and pad constants
    localparam logic [15:0] OP_STORE_ACC = 16'h5000;
    localparam logic [15:0] OP_LOAD_ACC = 16'h4000;
    localparam logic [15:0] OP_IND_MASK = 16'hFF00;
    localparam logic [15:0] OP_IND_LOAD = 16'hCD00;
    localparam logic [15:0] HALT_WORD = 16'h0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONE = 16'h0001;
    localparam logic [7:0] DISP_PAD = 8'h00;

    // general-purpose register codes
    localparam logic [2:0] GPR_ACC = 3'h0;
    localparam logic [2:0] GPR_INDEX = 3'h1;
    localparam logic [2:0] GPR_BASE = 3'h6;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ENTRY = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_PC = 8'h10;
    localparam logic [7:0] REG_IR = 8'h14;
    localparam logic [7:0] REG_LAMPS = 8'h18;
    localparam logic [7:0] REG_OPADDR = 8'h1C;
    localparam logic [7:0] REG_GPR0 = 8'h20;
    localparam logic [7:0] REG_GPR_MASK = 8'hE0;

    // command and status bit positions
    localparam int CMD_ENTER = 0;
    localparam int CMD_STEP = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_WAIT = 1;

    typedef struct packed {
        logic [2:0] gprCode;
        logic keep;
        logic irSel;
        logic pcSel;
    } clse_ctrl_t;

    localparam clse_ctrl_t CTRL_RST = '0;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [15:0] data;
    } clse_mem_req_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_EXEC = 4'b0100,
        ST_INDIR = 4'b1000
    } clse_state_t;
endpackage

// ===== rtl/clse_core_mem.sv
// core memory array seen by the console step sequencer
// assumes one write per cycle; reads are combinational from the array
`timescale 1ns/100ps
module clse_core_mem import clse_pkg::*; #(
    parameter int WORDS = 65536
) (
    input wire logic clk,
    input wire clse_mem_req_t req,
    output logic [15:0] rdata
);
    localparam int AW = $clog2(WORDS);

    generate
        if (WORDS < 2 || WORDS > 65536 || (1 << AW) != WORDS) begin : g_chk
            $error("clse_core_mem: WORDS must be a power of two up to 65536");
        end
    endgenerate

    logic [15:0] mem [WORDS];
    wire logic [AW-1:0] index;

    // upper address bits fold onto a smaller array
    assign index = req.addr[AW-1:0];
    assign rdata = mem[index];

    always_ff @(posedge clk) begin
        if (req.we) begin
            mem[index] <= req.data;
        end
    end
endmodule

// ===== dv/clse_checker.sv
// port-level checks of the console step block
// assumes a master that holds each request until waitrequest is low
`timescale 1ns/100ps
module clse_checker import clse_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic [BUS_AW-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [BUS_DW-1:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [BUS_DW-1:0] readdata,
    input wire logic waitrequest,
    input wire logic [15:0] lamps
);
    logic [15:0] entry;
    wire enterCmd = write && address == REG_CMD && byteenable[0];
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            entry <= '0;
        end else if (write && address == REG_ENTRY) begin
            entry <= {byteenable[1] ? writedata[15:8] : entry[15:8],
                byteenable[0] ? writedata[7:0] : entry[7:0]};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_write_nowait: assert property (write |-> !waitrequest)
        else $error("write was stalled");
    chk_read_stall: assert property (
        read && !$past(read) |-> waitrequest) else $error("read not stalled");
    chk_read_bound: assert property (
        read |-> ##[0:1] !waitrequest) else $error("read never completed");
    chk_read_upper: assert property (
        read && !waitrequest |-> readdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    chk_enter_lamps: assert property (
        enterCmd && writedata[0] |=> lamps == entry)
        else $error("lamps do not show entered value");
    // a step shows its result at most four edges after the command
    chk_lamps_cause: assert property (
        !$stable(lamps) |-> $past(write) || $past(write, 2)
        || $past(write, 3) || $past(write, 4))
        else $error("lamps changed without a command");
    chk_unmapped_zero: assert property (
        read && !waitrequest && address >= 8'h40 |-> readdata == '0)
        else $error("unmapped read not zero");
    chk_cmd_readzero: assert property (
        read && !waitrequest && address == REG_CMD |-> readdata == '0)
        else $error("command register read not zero");
endmodule
bind clse_console clse_checker clse_checker_inst (.clk(clk), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .lamps(lamps));

// ===== dv/clse_panel.sv
// operator panel model: switches, keys and lamps reached over the bus
// assumes each task call starts just after a rising clk edge
`timescale 1ns/100ps
module clse_panel import clse_pkg::*; (
    input wire logic clk,
    output logic [BUS_AW-1:0] address,
    output logic read,
    output logic write,
    output logic [BUS_DW-1:0] writedata,
    output logic [3:0] byteenable,
    input wire logic [BUS_DW-1:0] readdata,
    input wire logic waitrequest
);
    initial begin
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        byteenable = 4'hF;
    end
    // released data is inverted so a stale value is never mistaken for live
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wrbe(a, d, 4'hF);
    endtask
    // byte lanes ride with the request; entry merges partial lanes, ctrl and cmd need lane 0
    task automatic wrbe(input logic [7:0] a, input logic [15:0] d,
                        input logic [3:0] be);
        address <= a;
        writedata <= {16'h0000, d};
        byteenable <= be;
        write <= 1'b1;
        do @(posedge clk); while (waitrequest);
        write <= 1'b0;
        writedata <= ~{16'h0000, d};
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        address <= a;
        read <= 1'b1;
        do @(posedge clk); while (waitrequest);
        d = readdata[15:0];
        read <= 1'b0;
        @(posedge clk);
    endtask
endmodule

// ===== dv/test_console_load_step_execute.sv
// self-checking bench of the console step block with a reference model
// assumes the panel model is the only master; memory shrunk to 4096 words
`timescale 1ns/100ps
module test_console_load_step_execute import clse_pkg::*;
;
    localparam int MW = 4096;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [BUS_AW-1:0] address;
    logic read, write, waitrequest;
    logic [BUS_DW-1:0] writedata, readdata;
    logic [3:0] byteenable;
    logic [15:0] lamps, rv;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 99;
    int mem[int];
    int g[8];
    int pc, ir, ctl, lm, p;
    initial begin
        forever #50 clk = ~clk;
    end
    clse_console #(.MEM_WORDS(MW)) clse_console_inst (.clk(clk),
        .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .lamps(lamps));
    clse_panel clse_panel_inst (.clk(clk), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest));
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic look(logic [7:0] a, string what, int exp);
        clse_panel_inst.rd(a, rv);
        check(what, rv, exp[15:0]);
    endtask
    task automatic ctrl(int v);
        clse_panel_inst.wr(REG_CTRL, v[15:0]);
        ctl = v;
    endtask
    task automatic enter(int v);
        clse_panel_inst.wr(REG_ENTRY, v[15:0]);
        clse_panel_inst.wr(REG_CMD, 16'h0001);
        lm = v;
        if (ctl[0]) pc = v;
        else if (ctl[1]) ir = v;
        else g[ctl[5:3]] = v;
        check("lamps", lamps, v[15:0]);
    endtask
    task automatic step();
        int a;
        clse_panel_inst.wr(REG_CMD, 16'h0002);
        rv = 16'h0001;
        for (int i = 0; i < 20 && rv[0]; i++) begin
            clse_panel_inst.rd(REG_STATUS, rv);
        end
        if (!ctl[2]) ir = mem[pc % MW];
        pc = (pc + 1) & 32'hFFFF;
        if (ir == 32'h5000) mem[pc % MW] = g[0];
        else if (ir == 32'h4000) g[0] = mem[pc % MW];
        else if (ir[15:8] == 8'hCD) begin
            a = (mem[(g[6] + ir[7:0]) % MW] + g[1]) & 32'hFFFF;
            g[0] = mem[a % MW];
        end
        if (ir == 32'h4000 || ir[15:8] == 8'hCD) lm = g[0];
        look(REG_PC, "pc", pc);
        look(REG_GPR0, "acc", g[0]);
        check("lamps", lamps, lm[15:0]);
    endtask
    task automatic store_at(int at, int d);
        ctrl(1);
        enter(at);
        ctrl(2);
        enter(32'h5000);
        ctrl(4);
        enter(d);
        step();
    endtask
    task automatic load_at(int at);
        ctrl(1);
        enter(at);
        ctrl(2);
        enter(32'h4000);
        ctrl(4);
        step();
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        store_at(32'h0EFE, 32'h00F0);
        store_at(32'h0100, 32'hAAAA);
        store_at(32'h0020, 32'hCD02);
        load_at(32'h0EFE);
        $display("test direct done");
        ctrl(8);
        enter(32'h0011);
        ctrl(48);
        enter(32'h0EFD);
        look(8'h24, "index", 32'h0011);
        look(8'h38, "base", 32'h0EFD);
        ctrl(1);
        enter(32'h0021);
        ctrl(0);
        step();
        look(REG_OPADDR, "opaddr", 32'h0101);
        look(REG_IR, "ir", 32'hCD02);
        $display("test indirect done");
        ctrl(2);
        enter(0);
        ctrl(4);
        step();
        look(REG_STATUS, "status", 2);
        clse_panel_inst.wr(8'h44, 16'hFFFF);
        look(8'h40, "unmapped", 0);
        $display("test halt done");
        for (int i = 0; i < 6; i++) begin
            p = (i == 0) ? 32'hFFFF : $random(seed) & 32'hFFFF;
            store_at(p, $random(seed) & 32'hFFFF);
            load_at(p);
        end
        $display("test random done");
        // low lane only; ctrl write without lane 0 ignored; step bit dropped
        ctrl(1);
        enter(32'h1234);
        clse_panel_inst.wrbe(REG_ENTRY, 16'hABCD, 4'h1);
        clse_panel_inst.wrbe(REG_CTRL, 16'h0002, 4'h2);
        clse_panel_inst.wr(REG_CMD, 16'h0003);
        pc = 32'h12CD;
        lm = 32'h12CD;
        check("lamps", lamps, lm[15:0]);
        look(REG_PC, "pc", pc);
        look(REG_CTRL, "ctrl", ctl);
        look(REG_CMD, "cmd", 0);
        $display("test lanes done");
        tally_and_finish();
    end
endmodule
